// [pkg/pdc_pkg.sv]
// shared constants and types of the pll divider counter control
package pdc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int R_W = 14;
  localparam int A_W = 6;
  localparam int B_W = 13;
  localparam int PRE_W = 6;
  localparam int SYNC_W = 2;

  localparam logic [ADDR_W-1:0] ADDR_REF_LOW = 10'h011;
  localparam logic [ADDR_W-1:0] ADDR_REF_HIGH = 10'h012;
  localparam logic [ADDR_W-1:0] ADDR_SWALLOW = 10'h013;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_LOW = 10'h014;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_HIGH = 10'h015;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 10'h016;

  localparam logic [7:0] RST_REF_LOW = 8'h01;
  localparam logic [5:0] RST_REF_HIGH = 6'h00;
  localparam logic [5:0] RST_SWALLOW = 6'h00;
  localparam logic [7:0] RST_MAIN_LOW = 8'h03;
  localparam logic [4:0] RST_MAIN_HIGH = 5'h00;
  localparam logic [7:0] RST_CONTROL = 8'h06;

  localparam int CTL_MIDSUPPLY = 7;
  localparam int CTL_RESET_REF = 6;
  localparam int CTL_RESET_FB = 5;
  localparam int CTL_RESET_ALL = 4;
  localparam int CTL_BYPASS = 3;
  localparam int CTL_PRE_HI = 2;
  localparam int CTL_PRE_LO = 0;

  localparam logic [2:0] PRE_FD1 = 3'h0;
  localparam logic [2:0] PRE_FD2 = 3'h1;
  localparam logic [2:0] PRE_DM2 = 3'h2;
  localparam logic [2:0] PRE_DM4 = 3'h3;
  localparam logic [2:0] PRE_DM8 = 3'h4;
  localparam logic [2:0] PRE_DM16 = 3'h5;
  localparam logic [2:0] PRE_DM32 = 3'h6;
  localparam logic [2:0] PRE_FD3 = 3'h7;

  localparam logic [PRE_W-1:0] P_1 = 6'h01;
  localparam logic [PRE_W-1:0] P_2 = 6'h02;
  localparam logic [PRE_W-1:0] P_3 = 6'h03;
  localparam logic [PRE_W-1:0] P_4 = 6'h04;
  localparam logic [PRE_W-1:0] P_8 = 6'h08;
  localparam logic [PRE_W-1:0] P_16 = 6'h10;
  localparam logic [PRE_W-1:0] P_32 = 6'h20;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pdc_reg_req_t;
endpackage

// [rtl/pdc_sync.sv]
// two-flop synchronisers with rising-edge pulses
`timescale 1ns/1ns
module pdc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] last;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // only the second flop reads meta
      always_ff @(posedge clk) begin
        if (reset) begin
          meta[i] <= 1'b0;
          stable[i] <= 1'b0;
          last[i] <= 1'b0;
          rise[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          stable[i] <= meta[i];
          last[i] <= stable[i];
          rise[i] <= stable[i] & ~last[i];
        end
      end
    end
  endgenerate
endmodule

// [rtl/pdc_divider.sv]
// tick divider with hold, pulses once every ratio ticks
`timescale 1ns/1ns
module pdc_divider #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output logic pulse
);
  logic [W-1:0] count;
  logic [W-1:0] last_count;

  // zero ratio treated as one so the divider never stalls
  assign last_count = (ratio == '0) ? '0 : ratio - 1'b1;

  always_ff @(posedge clk) begin
    if (reset || hold) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count >= last_count) begin
          count <= '0;
          pulse <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/pdc_top.sv]
// pll divider counters with their configuration registers
`timescale 1ns/1ns
module pdc_top (
  input wire logic clk,
  input wire logic reset,
  input wire pdc_pkg::pdc_reg_req_t reg_req,
  output logic [pdc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ref_clk_in,
  input wire logic vco_clk_in,
  output logic reference_pulse,
  output logic feedback_pulse,
  output logic prescaler_pulse,
  output logic charge_pump_midsupply,
  output logic fixed_divide_mode,
  output logic dual_modulus_mode
);
  import pdc_pkg::*;

  logic [7:0] reference_divider_low;
  logic [5:0] reference_divider_high;
  logic [5:0] swallow_count;
  logic [7:0] main_count_low;
  logic [4:0] main_count_high;
  logic [7:0] divider_control;

  logic [1:0] edge_rise;
  logic ref_tick;
  logic vco_tick;
  logic hold_ref;
  logic hold_fb;
  logic fixed_mode;
  logic [PRE_W-1:0] pre_base;
  logic [PRE_W-1:0] pre_modulus;
  logic [PRE_W-1:0] pre_count;
  logic pre_tick;
  logic [R_W-1:0] ref_ratio;
  logic [B_W-1:0] main_ratio;
  logic [B_W-1:0] main_value;
  logic [A_W-1:0] eff_swallow;
  logic [A_W-1:0] swallow_left;
  logic ref_div_pulse;
  logic main_div_pulse;

  function automatic logic is_fixed(input logic [2:0] code);
    is_fixed = (code == PRE_FD1) || (code == PRE_FD2) || (code == PRE_FD3);
  endfunction

  function automatic logic [PRE_W-1:0] base_of(input logic [2:0] code);
    case (code)
      PRE_FD1: base_of = P_1;
      PRE_FD2: base_of = P_2;
      PRE_DM2: base_of = P_2;
      PRE_DM4: base_of = P_4;
      PRE_DM8: base_of = P_8;
      PRE_DM16: base_of = P_16;
      PRE_DM32: base_of = P_32;
      PRE_FD3: base_of = P_3;
      default: base_of = P_1;
    endcase
  endfunction

  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      reference_divider_low <= RST_REF_LOW;
      reference_divider_high <= RST_REF_HIGH;
      swallow_count <= RST_SWALLOW;
      main_count_low <= RST_MAIN_LOW;
      main_count_high <= RST_MAIN_HIGH;
      divider_control <= RST_CONTROL;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_REF_LOW: reference_divider_low <= reg_req.wdata;
        ADDR_REF_HIGH: reference_divider_high <= reg_req.wdata[5:0];
        ADDR_SWALLOW: swallow_count <= reg_req.wdata[5:0];
        ADDR_MAIN_LOW: main_count_low <= reg_req.wdata;
        ADDR_MAIN_HIGH: main_count_high <= reg_req.wdata[4:0];
        ADDR_CONTROL: divider_control <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // register reads, unused bits and unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_REF_LOW: reg_rdata <= reference_divider_low;
        ADDR_REF_HIGH: reg_rdata <= {2'h0, reference_divider_high};
        ADDR_SWALLOW: reg_rdata <= {2'h0, swallow_count};
        ADDR_MAIN_LOW: reg_rdata <= main_count_low;
        ADDR_MAIN_HIGH: reg_rdata <= {3'h0, main_count_high};
        ADDR_CONTROL: reg_rdata <= divider_control;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // reference and vco come from other domains; sampled edges only
  pdc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({vco_clk_in, ref_clk_in}),
    .rise(edge_rise)
  );

  assign ref_tick = edge_rise[0];
  assign vco_tick = edge_rise[1];

  assign hold_ref = divider_control[CTL_RESET_REF] | divider_control[CTL_RESET_ALL];
  assign hold_fb = divider_control[CTL_RESET_FB] | divider_control[CTL_RESET_ALL];

  assign fixed_mode = is_fixed(divider_control[CTL_PRE_HI:CTL_PRE_LO]);
  assign pre_base = base_of(divider_control[CTL_PRE_HI:CTL_PRE_LO]);

  assign ref_ratio = {reference_divider_high, reference_divider_low};
  assign main_value = {main_count_high, main_count_low};

  // bypass ignored outside fixed divide mode
  assign main_ratio = (fixed_mode && divider_control[CTL_BYPASS]) ? 13'h0001 : main_value;

  // swallow limited to main count to keep the sequence defined
  assign eff_swallow = ({7'h00, swallow_count} > main_value) ?
                       main_value[A_W-1:0] : swallow_count;

  // extra vco cycle while swallow cycles remain
  assign pre_modulus = (!fixed_mode && swallow_left != '0) ?
                       pre_base + 1'b1 : pre_base;

  // reference divider
  pdc_divider #(
    .W(R_W)
  ) u_ref_div (
    .clk(clk),
    .reset(reset),
    .hold(hold_ref),
    .tick(ref_tick),
    .ratio(ref_ratio),
    .pulse(ref_div_pulse)
  );

  // prescaler
  always_ff @(posedge clk) begin
    if (reset || hold_fb) begin
      pre_count <= '0;
      pre_tick <= 1'b0;
    end else begin
      pre_tick <= 1'b0;
      if (vco_tick) begin
        if (pre_count >= pre_modulus - 1'b1) begin
          pre_count <= '0;
          pre_tick <= 1'b1;
        end else begin
          pre_count <= pre_count + 1'b1;
        end
      end
    end
  end

  // swallow counter, reloaded at each feedback period in dual modulus mode, held at zero in fixed divide mode
  always_ff @(posedge clk) begin
    if (reset || hold_fb) begin
      swallow_left <= fixed_mode ? '0 : eff_swallow;
    end else if (fixed_mode) begin
      swallow_left <= '0;
    end else if (main_div_pulse) begin
      swallow_left <= eff_swallow;
    end else if (pre_tick && swallow_left != '0) begin
      swallow_left <= swallow_left - 1'b1;
    end
  end

  // main counter counts prescaler periods
  pdc_divider #(
    .W(B_W)
  ) u_main_div (
    .clk(clk),
    .reset(reset),
    .hold(hold_fb),
    .tick(pre_tick),
    .ratio(main_ratio),
    .pulse(main_div_pulse)
  );

  // registered outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      reference_pulse <= 1'b0;
      feedback_pulse <= 1'b0;
      prescaler_pulse <= 1'b0;
      charge_pump_midsupply <= 1'b0;
      fixed_divide_mode <= 1'b0;
      dual_modulus_mode <= 1'b0;
    end else begin
      reference_pulse <= ref_div_pulse;
      feedback_pulse <= main_div_pulse;
      prescaler_pulse <= pre_tick;
      charge_pump_midsupply <= divider_control[CTL_MIDSUPPLY];
      fixed_divide_mode <= fixed_mode;
      dual_modulus_mode <= ~fixed_mode;
    end
  end
endmodule

// [bench/pdc_top_assertions.sv]
// concurrent checks on the divider control ports
`timescale 1ns/1ns
module pdc_top_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire pdc_pkg::pdc_reg_req_t reg_req,
  input wire logic [pdc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ref_clk_in,
  input wire logic vco_clk_in,
  input wire logic reference_pulse,
  input wire logic feedback_pulse,
  input wire logic prescaler_pulse,
  input wire logic charge_pump_midsupply,
  input wire logic fixed_divide_mode,
  input wire logic dual_modulus_mode
);
  import pdc_pkg::*;
  logic [7:0] ctl;
  logic fd;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // shadow of the control register, built only from writes seen at the port
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl <= RST_CONTROL;
    end else if (reg_req.wr && reg_req.addr == ADDR_CONTROL) begin
      ctl <= reg_req.wdata;
    end
  end
  assign fd = ctl[2:0] inside {PRE_FD1, PRE_FD2, PRE_FD3};
  sequence s_wr(a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence s_rd(a);
    reg_req.rd && !reg_req.wr && reg_req.addr == a;
  endsequence
  property p_wr_rd(a, m);
    s_wr(a) ##1 s_rd(a) |=> reg_rdata == ($past(reg_req.wdata, 2) & m);
  endproperty
  AST_REF_LOW: assert property (p_wr_rd(ADDR_REF_LOW, 8'hff))
    else $error("ref low readback");
  AST_REF_HIGH: assert property (p_wr_rd(ADDR_REF_HIGH, 8'h3f))
    else $error("ref high readback");
  AST_SWALLOW: assert property (p_wr_rd(ADDR_SWALLOW, 8'h3f))
    else $error("swallow readback");
  AST_MAIN_LOW: assert property (p_wr_rd(ADDR_MAIN_LOW, 8'hff))
    else $error("main low readback");
  AST_MAIN_HIGH: assert property (p_wr_rd(ADDR_MAIN_HIGH, 8'h1f))
    else $error("main high readback");
  AST_MIDSUPPLY: assert property (s_wr(ADDR_CONTROL) ##1 !reg_req.wr
    |=> charge_pump_midsupply == $past(reg_req.wdata[7], 2)) else $error("midsupply");
  // three cycles of hold let a pulse already in the pipe drain
  AST_REF_HELD: assert property ((ctl[6] || ctl[4])[*3] |-> !reference_pulse)
    else $error("ref pulse in hold");
  AST_FB_HELD: assert property ((ctl[5] || ctl[4])[*3] |-> !feedback_pulse)
    else $error("fb pulse in hold");
  AST_MODE: assert property (!$past(reset) |-> fixed_divide_mode == $past(fd)
    && dual_modulus_mode == !$past(fd)) else $error("mode outputs");
endmodule

// [bench/pdc_top_bench.sv]
// self-checking bench for the divider control block
`timescale 1ns/1ns
module pdc_top_bench;
  import pdc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  pdc_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic ref_clk_in = 1'b0;
  logic vco_clk_in = 1'b0;
  logic reference_pulse, feedback_pulse, prescaler_pulse;
  logic charge_pump_midsupply, fixed_divide_mode, dual_modulus_mode;
  int err_count = 0;
  int n_tests = 0;
  int ref_seen = 0;
  int fb_seen = 0;
  int pre_seen = 0;
  // every prescaler code, plus a zero swallow and a swallow above main
  logic [7:0] ctls [12] = '{8'h01, 8'h09, 8'h0f, 8'h08, 8'h02, 8'h0a,
    8'h03, 8'h04, 8'h05, 8'h06, 8'h03, 8'h02};
  int swl [12] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 0, 5};
  int ns [12] = '{6, 2, 3, 1, 8, 8, 14, 26, 50, 98, 12, 9};
  int pre_exp [12] = '{7, 2, 2, 2, 7, 7, 7, 7, 7, 7, 7, 7};
  always #2 clk = ~clk;
  pdc_top uut (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ref_clk_in(ref_clk_in), .vco_clk_in(vco_clk_in), .reference_pulse(reference_pulse),
    .feedback_pulse(feedback_pulse), .prescaler_pulse(prescaler_pulse),
    .charge_pump_midsupply(charge_pump_midsupply), .fixed_divide_mode(fixed_divide_mode),
    .dual_modulus_mode(dual_modulus_mode));
  always @(posedge clk) begin
    ref_seen <= ref_seen + (reference_pulse === 1'b1);
    fb_seen <= fb_seen + (feedback_pulse === 1'b1);
    pre_seen <= pre_seen + (prescaler_pulse === 1'b1);
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  // write then read back to back, so the read-after-write check fires
  task automatic wrrd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(a, d);
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // n rising pin edges three cycles apart, then count the pulses seen
  task automatic drive(input bit vco, input int n, input int exp);
    int r0;
    int f0;
    r0 = ref_seen;
    f0 = fb_seen;
    repeat (n) begin
      @(posedge clk);
      vco_clk_in <= vco;
      ref_clk_in <= !vco;
      repeat (2) @(posedge clk);
      vco_clk_in <= 1'b0;
      ref_clk_in <= 1'b0;
    end
    repeat (12) @(posedge clk);
    chk(8'(vco ? fb_seen - f0 : ref_seen - r0), 8'(exp));
  endtask
  task automatic t_regs();
    wrrd(ADDR_CONTROL, RST_CONTROL, RST_CONTROL);
    chk({7'h0, dual_modulus_mode}, 8'h01);
    chk({7'h0, charge_pump_midsupply}, 8'h00);
    wrrd(ADDR_REF_LOW, 8'hff, 8'hff);
    wrrd(ADDR_REF_HIGH, 8'hff, 8'h3f);
    wrrd(ADDR_SWALLOW, 8'hff, 8'h3f);
    wrrd(ADDR_MAIN_LOW, 8'hff, 8'hff);
    wrrd(ADDR_MAIN_HIGH, 8'hff, 8'h1f);
    wrrd(10'h3ff, 8'hff, 8'h00);
    wr(ADDR_CONTROL, 8'h86);
    @(posedge clk);
    #1 chk({7'h0, charge_pump_midsupply}, 8'h01);
    $display("register test done");
  endtask
  task automatic t_reference();
    wr(ADDR_REF_LOW, 8'h05);
    wr(ADDR_REF_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h46);
    wr(ADDR_CONTROL, 8'h06);
    drive(0, 12, 2);
    wr(ADDR_REF_LOW, 8'h01);
    wr(ADDR_REF_HIGH, 8'h01);
    wr(ADDR_CONTROL, 8'h16);
    wr(ADDR_CONTROL, 8'h06);
    drive(0, 385, 1);
    wr(ADDR_REF_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h46);
    drive(0, 6, 0);
    wr(ADDR_CONTROL, 8'h16);
    drive(0, 6, 0);
    wr(ADDR_CONTROL, 8'h26);
    drive(0, 6, 6);
    drive(1, 40, 0);
    $display("reference test done");
  endtask
  task automatic t_feedback();
    int p0;
    wr(ADDR_SWALLOW, 8'h02);
    wr(ADDR_MAIN_LOW, 8'h03);
    wr(ADDR_MAIN_HIGH, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(ADDR_SWALLOW, 8'(swl[i]));
      wr(ADDR_CONTROL, ctls[i] | 8'h10);
      wr(ADDR_CONTROL, ctls[i]);
      p0 = pre_seen;
      drive(1, 2 * ns[i] + ns[i] / 2, 2);
      // two and a half feedback periods end mid-way through a prescaler period, except in the divide-by-one case where ns[i] / 2 is zero
      chk(8'(pre_seen - p0), 8'(pre_exp[i]));
      chk({7'h0, fixed_divide_mode}, {7'h0, ctls[i][2:0] inside {3'h0, 3'h1, 3'h7}});
    end
    $display("feedback test done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("timeout");
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_reference();
    t_feedback();
    print_verdict();
  end
endmodule
bind pdc_top pdc_top_assertions chk_i (.clk(clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in), .vco_clk_in(vco_clk_in),
  .reference_pulse(reference_pulse), .feedback_pulse(feedback_pulse),
  .prescaler_pulse(prescaler_pulse), .charge_pump_midsupply(charge_pump_midsupply),
  .fixed_divide_mode(fixed_divide_mode), .dual_modulus_mode(dual_modulus_mode));
